/* File: common/fbcs_cfg.svh */
// constants for the flash buffer command and status block
`ifndef FBCS_CFG_SVH
`define FBCS_CFG_SVH
`define FBCS_OP_XFR_B1     8'h53
`define FBCS_OP_XFR_B2     8'h55
`define FBCS_OP_CMP_B1     8'h60
`define FBCS_OP_CMP_B2     8'h61
`define FBCS_OP_RWR_B1     8'h58
`define FBCS_OP_RWR_B2     8'h59
`define FBCS_OP_STATUS     8'hd7
`define FBCS_CMD_BITS      6'd32
`define FBCS_RDY_BIT       7
`define FBCS_COMP_BIT      6
`define FBCS_DENS_LSB      2
`define FBCS_PROT_BIT      1
`define FBCS_PSIZE_BIT     0
`define FBCS_EPE_BIT       5
`define FBCS_SLE_BIT       3
`define FBCS_PS2_BIT       2
`define FBCS_PS1_BIT       1
`define FBCS_ES_BIT        0
`define FBCS_PG528_LSB     10
`define FBCS_PG512_LSB     9
`define FBCS_CLK_NS        4
`define FBCS_XFR_NS        200
`define FBCS_COMP_NS       200
`define FBCS_EP_NS         4000
`define FBCS_XFR_CYC       (`FBCS_XFR_NS / `FBCS_CLK_NS)
`define FBCS_COMP_CYC      (`FBCS_COMP_NS / `FBCS_CLK_NS)
`define FBCS_EP_CYC        (`FBCS_EP_NS / `FBCS_CLK_NS)
`define FBCS_SCK_HALF      4'd4
`define FBCS_ADDR_STATUS   2'h0
`define FBCS_ADDR_CMD      2'h1
`define FBCS_ADDR_PAGE     2'h2
`define FBCS_ADDR_RESULT   2'h3
`endif

/* File: common/fbcs_pkg.sv */
// operation type reported by the device end of the flash buffer command link and checked by the bench
package fbcs_pkg;
  typedef enum logic [1:0] {fbcs_op_none, fbcs_op_xfr, fbcs_op_cmp, fbcs_op_rwr} fbcs_op_t;
endpackage : fbcs_pkg

/* File: common/fbcs_if.sv */
// serial link between host controller and flash command block
`timescale 1ns/1ns
interface fbcs_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev  (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface : fbcs_if

/* File: hdl/fbcs_device.sv */
// flash device end: command shifter, self-timed ops, status output
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "fbcs_cfg.svh"
// How it works
// - 53h/55h copy page to buffer
// - 528 mode: 1 dummy, page, 10 dummy
// - 512 mode: 2 dummy, page, 9 dummy
// - shift while selected; start on deselect
// - busy during page copy
// - 60h/61h compare page with buffer
// - compare on deselect, busy meanwhile
// - compare result to byte-one bit 6
// - 58h/59h refresh page via buffer
// - refresh copies then programs back
// - refresh busy for erase-program time
// - host refreshes pages within 50000 cycles; fbcs_host keeps no count and refreshes only on a command write
// - D7h then status bit per clock
// - status repeats byte one after two
// - fresh sample per byte; bit 7 ready
// - deselect ends read, floats output
// - status read allowed any time
// - byte-one bit 1 shows protection
// - byte-one bit 0 shows page size
// - byte-two bit 5 error; 6,4 zero
// - byte-two bit 3 lockdown allowed
// - byte-two bits 2,1,0 suspend flags
module fbcs_device
  import fbcs_pkg::*;
#(
  parameter logic [3:0] DENSITY_CODE = 4'h5  // arbitrary value
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // serial link
  fbcs_if.dev       link,
  // array-side flags and page data
  input  wire logic page_512_mode,
  input  wire logic protect_enabled,
  input  wire logic erase_program_error_flag,
  input  wire logic lockdown_allowed_flag,
  input  wire logic buffer_two_program_suspended,
  input  wire logic buffer_one_program_suspended,
  input  wire logic erase_suspended_flag,
  input  wire logic page_mismatch,
  // operation reporting
  output logic      busy,
  output fbcs_pkg::fbcs_op_t op_kind,
  output logic      op_buffer_two,
  output logic [12:0] op_page
);
  import fbcs_pkg::*;

  logic [2:0]  cs_sync_r, sck_sync_r;
  logic [1:0]  si_sync_r;
  logic [31:0] shift_r;
  logic [5:0]  bit_cnt_r;
  logic        status_mode_r;
  logic [3:0]  out_idx_r;
  logic [15:0] status_snap_r;
  logic [31:0] op_cnt_r;
  logic        so_r, so_oe_r, comp_r;
  logic        rwr_phase2_r;
  logic [7:0]  byte_one, byte_two;
  wire         cs_low    = ~cs_sync_r[1];
  wire         cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
  wire         sck_rise  = sck_sync_r[1] & ~sck_sync_r[2];
  wire         sck_fall  = ~sck_sync_r[1] & sck_sync_r[2];
  wire [7:0]   op_byte   = shift_r[31:24];

  // pins pass two flops; stage 3 only feeds edge detection from stage 2
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      cs_sync_r  <= 3'h7;
      sck_sync_r <= 3'h0;
      si_sync_r  <= 2'h0;
    end
    else if (clk_en)
    begin
      cs_sync_r  <= {cs_sync_r[1:0], link.cs_n};
      sck_sync_r <= {sck_sync_r[1:0], link.sck};
      si_sync_r  <= {si_sync_r[0], link.si};
    end

  always_comb
  begin
    byte_one = 8'h00;
    byte_one[`FBCS_RDY_BIT] = ~busy;
    byte_one[`FBCS_COMP_BIT] = comp_r;
    byte_one[`FBCS_DENS_LSB +: 4] = DENSITY_CODE;
    byte_one[`FBCS_PROT_BIT] = protect_enabled;
    byte_one[`FBCS_PSIZE_BIT] = page_512_mode;
    byte_two = 8'h00;
    byte_two[`FBCS_RDY_BIT] = ~busy;
    byte_two[`FBCS_EPE_BIT] = erase_program_error_flag;
    byte_two[`FBCS_SLE_BIT] = lockdown_allowed_flag;
    byte_two[`FBCS_PS2_BIT] = buffer_two_program_suspended;
    byte_two[`FBCS_PS1_BIT] = buffer_one_program_suspended;
    byte_two[`FBCS_ES_BIT] = erase_suspended_flag;
  end

  // command shift; mode 0, sample on sck rise
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      shift_r   <= 32'h0;
      bit_cnt_r <= 6'h0;
    end
    else if (clk_en)
    begin
      if (!cs_low)
        bit_cnt_r <= 6'h0;
      else if (sck_rise && bit_cnt_r != 6'h3f)
      begin
        shift_r   <= {shift_r[30:0], si_sync_r[1]};
        bit_cnt_r <= bit_cnt_r + 6'h1;
      end
    end

  // status read; output changes on sck fall, accepted even while busy
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      status_mode_r <= 1'b0;
      out_idx_r     <= 4'h0;
      status_snap_r <= 16'h0;
      so_r          <= 1'b0;
      so_oe_r       <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!cs_low)
      begin
        status_mode_r <= 1'b0;
        so_oe_r       <= 1'b0;
      end
      else if (!status_mode_r && bit_cnt_r == 6'd8 && shift_r[7:0] == `FBCS_OP_STATUS)
      begin
        status_mode_r <= 1'b1;
        out_idx_r     <= 4'h0;
      end
      else if (status_mode_r && sck_fall)
      begin
        if (out_idx_r == 4'h0)
        begin
          status_snap_r <= {byte_one, byte_two};
          so_r          <= byte_one[7];
        end
        else if (out_idx_r == 4'h8)
        begin
          status_snap_r[7:0] <= byte_two;
          so_r               <= byte_two[7];
        end
        else if (out_idx_r < 4'h8)
          so_r <= status_snap_r[4'd15 - out_idx_r];
        else
          so_r <= status_snap_r[4'd15 - out_idx_r];
        so_oe_r   <= 1'b1;
        out_idx_r <= out_idx_r + 4'h1;
      end
    end

  // self-timed operation launch and timing
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      busy          <= 1'b0;
      op_kind       <= fbcs_op_none;
      op_buffer_two <= 1'b0;
      op_page       <= 13'h0;
      op_cnt_r      <= 32'h0;
      rwr_phase2_r  <= 1'b0;
      comp_r        <= 1'b0;
    end
    else if (clk_en)
    begin
      if (busy)
      begin
        if (op_cnt_r > 32'h1)
          op_cnt_r <= op_cnt_r - 32'h1;
        else if (op_kind == fbcs_op_rwr && !rwr_phase2_r)
        begin
          rwr_phase2_r <= 1'b1;
          op_cnt_r     <= 32'(`FBCS_EP_CYC - `FBCS_XFR_CYC);
        end
        else
        begin
          if (op_kind == fbcs_op_cmp)
            comp_r <= page_mismatch;
          busy    <= 1'b0;
          op_kind <= fbcs_op_none;
        end
      end
      else if (cs_rise && bit_cnt_r == `FBCS_CMD_BITS)
      begin
        // buffer choice is not one opcode bit across all three pairs, so decode it fully
        op_buffer_two <= op_byte == `FBCS_OP_XFR_B2 || op_byte == `FBCS_OP_CMP_B2
                         || op_byte == `FBCS_OP_RWR_B2;
        op_page       <= page_512_mode ? shift_r[`FBCS_PG512_LSB +: 13]
                                       : shift_r[`FBCS_PG528_LSB +: 13];
        rwr_phase2_r  <= 1'b0;
        if (op_byte == `FBCS_OP_XFR_B1 || op_byte == `FBCS_OP_XFR_B2)
        begin
          busy     <= 1'b1;
          op_kind  <= fbcs_op_xfr;
          op_cnt_r <= 32'(`FBCS_XFR_CYC);
        end
        else if (op_byte == `FBCS_OP_CMP_B1 || op_byte == `FBCS_OP_CMP_B2)
        begin
          busy     <= 1'b1;
          op_kind  <= fbcs_op_cmp;
          op_cnt_r <= 32'(`FBCS_COMP_CYC);
        end
        else if (op_byte == `FBCS_OP_RWR_B1 || op_byte == `FBCS_OP_RWR_B2)
        begin
          busy     <= 1'b1;
          op_kind  <= fbcs_op_rwr;
          op_cnt_r <= 32'(`FBCS_XFR_CYC);
        end
      end
    end

  assign link.so    = so_r;
  assign link.so_oe = so_oe_r;
endmodule : fbcs_device

/* File: hdl/fbcs_host.sv */
// host end: register port drives command frames and status polling
`timescale 1ns/1ns
`include "fbcs_cfg.svh"
module fbcs_host
  import fbcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // serial link
  fbcs_if.host             link
);
  import fbcs_pkg::*;

  typedef enum logic [1:0] {fbcs_h_idle, fbcs_h_shift, fbcs_h_gap} fbcs_hstate_t;
  fbcs_hstate_t state_r;
  logic [7:0]  cmd_op_r;
  logic [12:0] page_r;
  logic        mode_512_r;
  logic [31:0] tx_r;
  logic [5:0]  bits_left_r;
  logic [3:0]  div_r;
  logic        sck_r, cs_n_r, si_r, read_r;
  logic [1:0]  so_sync_r;
  logic [15:0] rx_r, status_r;
  logic [4:0]  rx_cnt_r;
  wire  [31:0] frame = mode_512_r ? {cmd_op_r, 2'h0, page_r, 9'h0}
                                  : {cmd_op_r, 1'h0, page_r, 10'h0};

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      so_sync_r <= 2'h0;
    else if (clk_en)
      so_sync_r <= {so_sync_r[0], link.so};

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      page_r     <= 13'h0;
      mode_512_r <= 1'b0;
    end
    else if (clk_en && reg_wr && reg_addr == `FBCS_ADDR_PAGE)
    begin
      page_r     <= reg_wdata[12:0];
      mode_512_r <= reg_wdata[16];
    end

  // status read (opcode D7h) streams 16 bits; other opcodes send 32
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      state_r     <= fbcs_h_idle;
      cmd_op_r    <= 8'h0;
      tx_r        <= 32'h0;
      bits_left_r <= 6'h0;
      div_r       <= 4'h0;
      sck_r       <= 1'b0;
      cs_n_r      <= 1'b1;
      si_r        <= 1'b0;
      read_r      <= 1'b0;
      rx_r        <= 16'h0;
      rx_cnt_r    <= 5'h0;
      status_r    <= 16'h0;
    end
    else if (clk_en)
    begin
      case (state_r)
        fbcs_h_idle:
          if (reg_wr && reg_addr == `FBCS_ADDR_CMD)
          begin
            cmd_op_r    <= reg_wdata[7:0];
            read_r      <= reg_wdata[7:0] == `FBCS_OP_STATUS;
            tx_r        <= {reg_wdata[7:0], frame[23:0]};
            bits_left_r <= reg_wdata[7:0] == `FBCS_OP_STATUS ? 6'd24 : `FBCS_CMD_BITS;
            cs_n_r      <= 1'b0;
            si_r        <= reg_wdata[7];
            div_r       <= 4'h0;
            rx_cnt_r    <= 5'h0;
            state_r     <= fbcs_h_shift;
          end
        fbcs_h_shift:
          if (div_r == `FBCS_SCK_HALF - 4'h1)
          begin
            div_r <= 4'h0;
            sck_r <= ~sck_r;
            if (!sck_r)
            begin
              bits_left_r <= bits_left_r - 6'h1;
              tx_r        <= {tx_r[30:0], 1'b0};
            end
            else
            begin
              // so returns through two synchronisers on each side, longer than a
              // half period, so each bit is taken just before sck falls instead
              if (read_r && bits_left_r <= 6'd15)
              begin
                rx_r     <= {rx_r[14:0], so_sync_r[1]};
                rx_cnt_r <= rx_cnt_r + 5'h1;
              end
              if (bits_left_r == 6'h0)
              begin
                cs_n_r  <= 1'b1;
                state_r <= fbcs_h_gap;
                if (read_r)
                  status_r <= {rx_r[14:0], so_sync_r[1]};
              end
              else
                si_r <= tx_r[31];
            end
          end
          else
            div_r <= div_r + 4'h1;
        fbcs_h_gap:
          if (div_r == `FBCS_SCK_HALF)
          begin
            div_r   <= 4'h0;
            state_r <= fbcs_h_idle;
          end
          else
            div_r <= div_r + 4'h1;
        default:
          state_r <= fbcs_h_idle;
      endcase
    end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      reg_rdata <= 32'h0;
    else if (clk_en && reg_rd)
    begin
      if (reg_addr == `FBCS_ADDR_STATUS)
        reg_rdata <= {31'h0, state_r != fbcs_h_idle};
      else if (reg_addr == `FBCS_ADDR_CMD)
        reg_rdata <= {24'h0, cmd_op_r};
      else if (reg_addr == `FBCS_ADDR_PAGE)
        reg_rdata <= {15'h0, mode_512_r, 3'h0, page_r};
      else
        reg_rdata <= {16'h0, status_r};
    end

  assign link.cs_n = cs_n_r;
  assign link.sck  = sck_r;
  assign link.si   = si_r;
endmodule : fbcs_host

/* File: test/fbcs_asserts.sv */
// concurrent checks on the serial link between host and device
`timescale 1ns/1ns
module fbcs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_d_r;
  logic [5:0] rise_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      sck_d_r <= 1'b0;
    else
      sck_d_r <= sck;

  // saturates so a runaway frame cannot wrap back to a legal count
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      rise_cnt_r <= 6'h00;
    else if (cs_n)
      rise_cnt_r <= 6'h00;
    else if (sck && !sck_d_r && rise_cnt_r != 6'h3f)
      rise_cnt_r <= rise_cnt_r + 6'h01;

  sequence sck_high_phase;
    sck[*4] ##1 !sck;
  endsequence
  sequence deselect_gap;
    cs_n[*5];
  endsequence

  AST_SCK_HALF: assert property ($rose(sck) |-> sck_high_phase)
    else $error("sck high phase not four cycles");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  AST_SI_HOLD: assert property (sck && $past(sck) |-> $stable(si))
    else $error("si moved while sck high");
  AST_CS_LEAD: assert property ($fell(cs_n) |-> !sck[*2])
    else $error("sck rose with select");
  AST_CS_GAP: assert property ($rose(cs_n) |-> deselect_gap)
    else $error("deselect gap too short");
  AST_SO_HOLD: assert property (so_oe && sck && $past(sck) |-> $stable(so))
    else $error("so moved while sck high");
  AST_OE_BYTE: assert property ($rose(so_oe) |-> rise_cnt_r == 6'h08)
    else $error("so driven before opcode complete");
  AST_SO_SEL: assert property ($rose(so_oe) |-> !cs_n)
    else $error("so driven while deselected");
  AST_SO_FLOAT: assert property ($rose(cs_n) |-> ##[0:5] !so_oe)
    else $error("so not floated after deselect");
endmodule : fbcs_asserts

/* File: test/flash_buffer_cmd_status_test.sv */
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ns
`include "fbcs_cfg.svh"
module flash_buffer_cmd_status_test;
  import fbcs_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [12:0] page;
    logic        m512;
    logic [5:0]  flags;
    logic        miss;
    fbcs_op_t    kind;
    logic        buf2;
    logic [15:0] cyc;
  } fbcs_row_t;
  localparam logic [3:0] DENS = 4'h9;  // arbitrary value
  logic        clk;
  logic        resetn;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [5:0]  fl;
  logic        m512;
  logic        miss;
  logic        busy;
  fbcs_op_t    op_kind;
  fbcs_op_t    kind_seen;
  logic        op_buffer_two;
  logic [12:0] op_page;
  logic [31:0] d;
  logic [15:0] s;
  logic        comp_exp;
  int          error_cnt;
  int          checks_done;
  int          cyc_cnt;
  int          bc;
  fbcs_row_t   rows [6];

  fbcs_if i_fbcs_if ();
  fbcs_device #(.DENSITY_CODE(DENS)) i_fbcs_device (.clk(clk), .resetn(resetn),
    .clk_en(1'b1), .link(i_fbcs_if), .page_512_mode(m512), .protect_enabled(fl[5]),
    .erase_program_error_flag(fl[4]), .lockdown_allowed_flag(fl[3]),
    .buffer_two_program_suspended(fl[2]), .buffer_one_program_suspended(fl[1]),
    .erase_suspended_flag(fl[0]), .page_mismatch(miss), .busy(busy),
    .op_kind(op_kind), .op_buffer_two(op_buffer_two), .op_page(op_page));
  fbcs_host i_fbcs_host (.clk(clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(i_fbcs_if));
  fbcs_asserts i_fbcs_asserts (.clk(clk), .resetn(resetn), .cs_n(i_fbcs_if.cs_n),
    .sck(i_fbcs_if.sck), .si(i_fbcs_if.si), .so(i_fbcs_if.so), .so_oe(i_fbcs_if.so_oe));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // busy length is counted here, not by polling, so poll latency cannot skew it
  always @(posedge clk)
  begin
    cyc_cnt++;
    // op_kind falls back to none when the operation ends, so keep what it showed while busy
    if (busy === 1'b1)
    begin
      bc++;
      kind_seen = op_kind;
    end
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [1:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task frame(input logic [7:0] op);
    wr(`FBCS_ADDR_CMD, {24'h0, op});
    repeat (3) @(posedge clk);
    for (int n = 0; n < 2000; n++)
    begin
      rd(`FBCS_ADDR_STATUS, d);
      if (d[0] !== 1'b1)
        break;
    end
  endtask : frame

  task status();
    frame(`FBCS_OP_STATUS);
    rd(`FBCS_ADDR_RESULT, d);
    s = d[15:0];
  endtask : status

  task settle();
    repeat (6) @(posedge clk);
    for (int n = 0; n < 2000 && busy !== 1'b0; n++)
      @(posedge clk);
  endtask : settle

  task print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    rows[0] = '{`FBCS_OP_XFR_B1, 13'h1fff, 0, 6'h20, 0, fbcs_op_xfr, 0, 16'(`FBCS_XFR_CYC)};
    rows[1] = '{`FBCS_OP_XFR_B2, 13'h0001, 1, 6'h10, 1, fbcs_op_xfr, 1, 16'(`FBCS_XFR_CYC)};
    rows[2] = '{`FBCS_OP_CMP_B1, 13'h1555, 0, 6'h08, 1, fbcs_op_cmp, 0, 16'(`FBCS_COMP_CYC)};
    rows[3] = '{`FBCS_OP_CMP_B2, 13'h0aaa, 1, 6'h04, 0, fbcs_op_cmp, 1, 16'(`FBCS_COMP_CYC)};
    rows[4] = '{`FBCS_OP_RWR_B1, 13'h0000, 1, 6'h02, 0, fbcs_op_rwr, 0, 16'(`FBCS_EP_CYC)};
    rows[5] = '{`FBCS_OP_RWR_B2, 13'h1234, 0, 6'h01, 0, fbcs_op_rwr, 1, 16'(`FBCS_EP_CYC)};
    {resetn, reg_addr, reg_wdata, reg_wr, reg_rd, fl, m512, miss} = '0;
    {error_cnt, checks_done, cyc_cnt, bc, comp_exp} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({busy, i_fbcs_if.cs_n, i_fbcs_if.so_oe, 1'b0 ^ (op_kind != fbcs_op_none)}, 32'h4);
    rd(`FBCS_ADDR_STATUS, d);
    chk(d, 32'h0);
    foreach (rows[i])
    begin
      @(posedge clk);
      fl <= rows[i].flags;
      m512 <= rows[i].m512;
      miss <= rows[i].miss;
      wr(`FBCS_ADDR_PAGE, {15'h0, rows[i].m512, 3'h0, rows[i].page});
      bc = 0;
      kind_seen = fbcs_op_none;
      frame(rows[i].op);
      settle();
      chk({30'h0, kind_seen}, {30'h0, rows[i].kind});
      chk({30'h0, op_kind}, {30'h0, fbcs_op_none});
      chk({18'h0, op_buffer_two, op_page}, {18'h0, rows[i].buf2, rows[i].page});
      chk(32'(bc + 2 >= rows[i].cyc && bc <= rows[i].cyc + 2), 32'h1);
      if (rows[i].kind == fbcs_op_cmp)
        comp_exp = rows[i].miss;
      status();
      chk({16'h0, s}, {16'h0, 1'b1, comp_exp, DENS, fl[5], m512, 1'b1, 1'b0, fl[4], 1'b0,
        fl[3:0]});
    end
    // status during a long refresh, and a command sent while busy is dropped
    frame(`FBCS_OP_RWR_B1);
    status();
    chk({s[15], s[7]}, 32'h0);
    frame(`FBCS_OP_XFR_B2);
    chk({30'h0, op_kind}, {30'h0, fbcs_op_rwr});
    // reset in mid-operation clears busy and releases the link
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({busy, i_fbcs_if.cs_n, i_fbcs_if.so_oe}, 32'h2);
    repeat (5) @(posedge clk);
    status();
    chk({s[15], s[7]}, 32'h3);
    print_verdict();
  end
endmodule : flash_buffer_cmd_status_test
